// >>> verilog/regfile_pkg.sv
// Shared types and constants of the banked processor register file.
// Assumes one core clock and a synchronous active-low reset.
package regfile_pkg;

  localparam int unsigned DATA_W     = 32;
  localparam int unsigned GPR_IDX_W  = 4;
  localparam int unsigned BANK_IDX_W = 3;
  localparam int unsigned PHYS_W     = 5;
  localparam int unsigned PHYS_WORDS = 24;
  localparam int unsigned RD_PORTS   = 4;

  // Physical word bases of bank zero, bank one and the unbanked registers.
  localparam logic [PHYS_W-1:0] BANK0_BASE   = 5'h00;
  localparam logic [PHYS_W-1:0] BANK1_BASE   = 5'h08;
  localparam logic [PHYS_W-1:0] UNBANKED_BASE = 5'h10;

  // Read port roles inside the register memory.
  localparam int unsigned PORT_A    = 0;
  localparam int unsigned PORT_B    = 1;
  localparam int unsigned PORT_IDX  = 2;
  localparam int unsigned PORT_BANK = 3;

  // Status word field positions.
  localparam int unsigned SW_T_POS    = 0;
  localparam int unsigned SW_S_POS    = 1;
  localparam int unsigned SW_IMASK_LO = 4;
  localparam int unsigned SW_IMASK_HI = 7;
  localparam int unsigned SW_BLOCK_POS = 28;
  localparam int unsigned SW_BANK_POS = 29;
  localparam int unsigned SW_MODE_POS = 30;

  // Bits that only privileged mode may see or change, and bits that exist at all.
  localparam logic [DATA_W-1:0] SW_PRIV_MASK  = 32'h7000_00F0;
  localparam logic [DATA_W-1:0] SW_VALID_MASK = 32'h7000_03F3;

  localparam logic [DATA_W-1:0] SW_RESET   = 32'h7000_00F0;
  localparam logic [DATA_W-1:0] VBR_RESET  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] IP_RESET   = 32'hA000_0000;
  localparam logic [DATA_W-1:0] ZERO_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] IP_STEP    = 32'h0000_0002;

  typedef enum logic [2:0] {
    CTL_STATUS = 3'b000,
    CTL_GBASE  = 3'b001,
    CTL_SSTAT  = 3'b011,
    CTL_SRET   = 3'b010,
    CTL_VBASE  = 3'b110,
    CTL_BANK   = 3'b111
  } ctl_sel_e;

  typedef enum logic [1:0] {
    SYS_MUL_ACC_HIGH = 2'b00,
    SYS_MUL_ACC_LOW = 2'b01,
    SYS_PROC = 2'b11,
    SYS_IP   = 2'b10
  } sys_sel_e;

  typedef struct packed {
    logic [GPR_IDX_W-1:0] idx_a;
    logic [GPR_IDX_W-1:0] idx_b;
    logic                 wr_en;
    logic [GPR_IDX_W-1:0] wr_idx;
    logic [DATA_W-1:0]    wr_data;
  } gpr_req_s;

  typedef struct packed {
    logic                  load;
    logic                  store;
    ctl_sel_e              sel;
    logic [BANK_IDX_W-1:0] bank_idx;
    logic [DATA_W-1:0]     data;
  } ctl_req_s;

  typedef struct packed {
    logic              load;
    logic              store;
    sys_sel_e          sel;
    logic [DATA_W-1:0] data;
  } sys_req_s;

  typedef struct packed {
    logic              exc_take;
    logic              irq_take;
    logic              ret_exc;
    logic              ip_step;
    logic [DATA_W-1:0] vec_offset;
  } flow_req_s;

  typedef struct packed {
    logic              we;
    logic [PHYS_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
  } mem_wr_s;

endpackage

// >>> verilog/regfile_mem.sv
// Register memory holding both low banks and the unbanked general registers.
// Assumes the owner resolves bank mapping; read data appear one cycle after the address.
module regfile_mem
  import regfile_pkg::*;
(
  input  wire logic                              mclk_i,
  input  wire logic                              rst_n_i,
  input  wire logic [RD_PORTS-1:0][PHYS_W-1:0]   raddr_i,
  input  wire mem_wr_s                           wr_i,
  output logic      [RD_PORTS-1:0][DATA_W-1:0]   rdata_o
);

  typedef struct packed {
    logic [PHYS_WORDS-1:0][DATA_W-1:0] words;
    logic [RD_PORTS-1:0][DATA_W-1:0]   rdata;
  } mem_state_s;

  mem_state_s st_reg;
  mem_state_s st_next;

  // A read of the word being written returns the old contents.
  always_comb begin
    st_next = st_reg;
    for (int p = 0; p < RD_PORTS; p++) begin
      st_next.rdata[p] = st_reg.words[raddr_i[p]];
    end
    if (wr_i.we) begin
      st_next.words[wr_i.waddr] = wr_i.wdata;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_o = st_reg.rdata;

endmodule

// >>> verilog/banked_cpu_register_file.sv
// Banked general, control and system registers of the processor core.
// Assumes the decode and execute pipeline drives at most one request of each group per cycle.
// Read data of every group arrive one cycle after the request.

// Overview of operation
// - Two modes: user and privileged.
// - Exception or accepted interrupt enters privileged mode.
// - Sixteen general registers; low eight doubly banked.
// - Privileged, bank bit one: low numbers hit bank one.
// - Privileged, bank bit zero: low numbers hit bank zero.
// - User mode sees bank zero only.
// - Saved, vector and other-bank registers privileged; others shared.
// - Bank and mode status bits privileged only.
// - Multiply, return and pointer registers mode independent.
// - Status mode bit selects current mode.
// - Register zero supplies the index operand.
// - Reset sets mode and bank bits.
// - Exception saves pointer; return restores it.
module banked_cpu_register_file
  import regfile_pkg::*;
(
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  input  wire gpr_req_s           gpr_req_i,
  input  wire ctl_req_s           ctl_req_i,
  input  wire sys_req_s           sys_req_i,
  input  wire flow_req_s          flow_req_i,
  output logic      [DATA_W-1:0]  rd_a_o,
  output logic      [DATA_W-1:0]  rd_b_o,
  output logic      [DATA_W-1:0]  index_reg_o,
  output logic      [DATA_W-1:0]  ctl_rd_o,
  output logic      [DATA_W-1:0]  sys_rd_o,
  output logic      [DATA_W-1:0]  status_word_o,
  output logic      [DATA_W-1:0]  instruction_pointer_o,
  output logic      [DATA_W-1:0]  vector_base_o,
  output logic                    privilege_mode_bit_o,
  output logic                    bank_select_bit_o,
  output logic                    illegal_access_o
);

  typedef struct packed {
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] global_base_reg;
    logic [DATA_W-1:0] saved_status_word;
    logic [DATA_W-1:0] saved_return_pointer;
    logic [DATA_W-1:0] vector_base_reg;
    logic [DATA_W-1:0] mul_acc_high;
    logic [DATA_W-1:0] mul_acc_low;
    logic [DATA_W-1:0] procedure_return_reg;
    logic [DATA_W-1:0] instruction_pointer;
    logic [DATA_W-1:0] ctl_rd;
    logic [DATA_W-1:0] sys_rd;
    logic              ctl_from_bank;
    logic              illegal;
  } rf_state_s;

  localparam rf_state_s RF_RESET = '{
    status_word:          SW_RESET,
    global_base_reg:      ZERO_RESET,
    saved_status_word:    ZERO_RESET,
    saved_return_pointer: ZERO_RESET,
    vector_base_reg:      VBR_RESET,
    mul_acc_high:         ZERO_RESET,
    mul_acc_low:          ZERO_RESET,
    procedure_return_reg: ZERO_RESET,
    instruction_pointer:  IP_RESET,
    ctl_rd:               ZERO_RESET,
    sys_rd:               ZERO_RESET,
    ctl_from_bank:        1'b0,
    illegal:              1'b0
  };

  rf_state_s st_reg;
  rf_state_s st_next;

  logic                             priv;
  logic                             bank_sel;
  logic [RD_PORTS-1:0][PHYS_W-1:0]  mem_raddr;
  logic [RD_PORTS-1:0][DATA_W-1:0]  mem_rdata;
  mem_wr_s                          mem_wr;
  logic                             ctl_priv_only;
  logic                             sw_priv_change;
  logic                             ctl_denied;
  logic                             ret_denied;

  // Maps an architectural register number to its physical word.
  function automatic logic [PHYS_W-1:0] gpr_phys(input logic [GPR_IDX_W-1:0] idx,
                                                 input logic                 md,
                                                 input logic                 rb);
    logic [PHYS_W-1:0] low;
    low = {2'b00, idx[BANK_IDX_W-1:0]};
    if (idx[GPR_IDX_W-1]) begin
      gpr_phys = UNBANKED_BASE + low;
    end else if (md && rb) begin
      gpr_phys = BANK1_BASE + low;
    end else begin
      gpr_phys = BANK0_BASE + low;
    end
  endfunction

  // Maps a bank index to the bank not currently in use as general registers.
  function automatic logic [PHYS_W-1:0] other_bank_phys(input logic [BANK_IDX_W-1:0] idx,
                                                        input logic                  rb);
    logic [PHYS_W-1:0] low;
    low = {2'b00, idx};
    other_bank_phys = rb ? (BANK0_BASE + low) : (BANK1_BASE + low);
  endfunction

  // Hides the privileged status bits from a user-mode reader.
  function automatic logic [DATA_W-1:0] sw_view(input logic [DATA_W-1:0] sw,
                                                input logic              md);
    sw_view = md ? sw : (sw & ~SW_PRIV_MASK);
  endfunction

  assign priv     = st_reg.status_word[SW_MODE_POS];
  assign bank_sel = st_reg.status_word[SW_BANK_POS];

  // In user mode the bank bit is ignored, so only bank zero is reachable.
  always_comb begin
    mem_raddr[PORT_A]    = gpr_phys(gpr_req_i.idx_a, priv, bank_sel);
    mem_raddr[PORT_B]    = gpr_phys(gpr_req_i.idx_b, priv, bank_sel);
    mem_raddr[PORT_IDX]  = gpr_phys('0, priv, bank_sel);
    mem_raddr[PORT_BANK] = other_bank_phys(ctl_req_i.bank_idx, bank_sel);
  end

  always_comb begin
    ctl_priv_only = (ctl_req_i.sel == CTL_SSTAT) || (ctl_req_i.sel == CTL_SRET) ||
                    (ctl_req_i.sel == CTL_VBASE) || (ctl_req_i.sel == CTL_BANK);
    sw_priv_change = ((ctl_req_i.data ^ st_reg.status_word) & SW_PRIV_MASK) != '0;
    ctl_denied = !priv && (ctl_req_i.load || ctl_req_i.store) &&
                 (ctl_priv_only || (ctl_req_i.load && (ctl_req_i.sel == CTL_STATUS) && sw_priv_change));
    ret_denied = !priv && flow_req_i.ret_exc;
  end

  // A general write takes the single write port ahead of a bank load.
  always_comb begin
    mem_wr.we    = 1'b0;
    mem_wr.waddr = '0;
    mem_wr.wdata = '0;
    if (gpr_req_i.wr_en) begin
      mem_wr.we    = 1'b1;
      mem_wr.waddr = gpr_phys(gpr_req_i.wr_idx, priv, bank_sel);
      mem_wr.wdata = gpr_req_i.wr_data;
    end else if (ctl_req_i.load && (ctl_req_i.sel == CTL_BANK) && priv) begin
      mem_wr.we    = 1'b1;
      mem_wr.waddr = other_bank_phys(ctl_req_i.bank_idx, bank_sel);
      mem_wr.wdata = ctl_req_i.data;
    end
  end

  always_comb begin
    st_next               = st_reg;
    st_next.illegal       = ctl_denied || ret_denied;
    st_next.ctl_from_bank = 1'b0;

    if (flow_req_i.ip_step) begin
      st_next.instruction_pointer = st_reg.instruction_pointer + IP_STEP;
    end

    // Control register transfers.
    if (ctl_req_i.store && !ctl_denied) begin
      case (ctl_req_i.sel)
        CTL_STATUS: st_next.ctl_rd = sw_view(st_reg.status_word, priv);
        CTL_GBASE:  st_next.ctl_rd = st_reg.global_base_reg;
        CTL_SSTAT:  st_next.ctl_rd = st_reg.saved_status_word;
        CTL_SRET:   st_next.ctl_rd = st_reg.saved_return_pointer;
        CTL_VBASE:  st_next.ctl_rd = st_reg.vector_base_reg;
        CTL_BANK:   st_next.ctl_from_bank = 1'b1;
        default:    st_next.ctl_rd = ZERO_RESET;
      endcase
    end
    if (ctl_req_i.load && !ctl_denied) begin
      case (ctl_req_i.sel)
        CTL_STATUS: st_next.status_word = ctl_req_i.data & SW_VALID_MASK;
        CTL_GBASE:  st_next.global_base_reg = ctl_req_i.data;
        CTL_SSTAT:  st_next.saved_status_word = ctl_req_i.data;
        CTL_SRET:   st_next.saved_return_pointer = ctl_req_i.data;
        CTL_VBASE:  st_next.vector_base_reg = ctl_req_i.data;
        default:    st_next.status_word = st_reg.status_word;
      endcase
    end

    // System register transfers, identical in both modes.
    if (sys_req_i.store) begin
      case (sys_req_i.sel)
        SYS_MUL_ACC_HIGH: st_next.sys_rd = st_reg.mul_acc_high;
        SYS_MUL_ACC_LOW: st_next.sys_rd = st_reg.mul_acc_low;
        SYS_PROC: st_next.sys_rd = st_reg.procedure_return_reg;
        SYS_IP:   st_next.sys_rd = st_reg.instruction_pointer;
        default:  st_next.sys_rd = ZERO_RESET;
      endcase
    end
    if (sys_req_i.load) begin
      case (sys_req_i.sel)
        SYS_MUL_ACC_HIGH: st_next.mul_acc_high = sys_req_i.data;
        SYS_MUL_ACC_LOW: st_next.mul_acc_low = sys_req_i.data;
        SYS_PROC: st_next.procedure_return_reg = sys_req_i.data;
        SYS_IP:   st_next.instruction_pointer = sys_req_i.data;
        default:  st_next.mul_acc_high = st_reg.mul_acc_high;
      endcase
    end

    // Return from exception restores the saved context.
    if (flow_req_i.ret_exc && priv) begin
      st_next.instruction_pointer = st_reg.saved_return_pointer;
      st_next.status_word         = st_reg.saved_status_word & SW_VALID_MASK;
    end

    // Exception or interrupt entry overrides any pointer, saved-register and mode, bank and block bit update in the cycle.
    if (flow_req_i.exc_take || flow_req_i.irq_take) begin
      st_next.saved_return_pointer = st_reg.instruction_pointer;
      st_next.saved_status_word    = st_reg.status_word;
      st_next.status_word[SW_MODE_POS]  = 1'b1;
      st_next.status_word[SW_BANK_POS]  = 1'b1;
      st_next.status_word[SW_BLOCK_POS] = 1'b1;
      st_next.instruction_pointer = st_reg.vector_base_reg + flow_req_i.vec_offset;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_reg <= RF_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  regfile_mem u_mem (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .raddr_i (mem_raddr),
    .wr_i    (mem_wr),
    .rdata_o (mem_rdata)
  );

  assign rd_a_o                = mem_rdata[PORT_A];
  assign rd_b_o                = mem_rdata[PORT_B];
  assign index_reg_o           = mem_rdata[PORT_IDX];
  assign ctl_rd_o              = st_reg.ctl_from_bank ? mem_rdata[PORT_BANK] : st_reg.ctl_rd;
  assign sys_rd_o              = st_reg.sys_rd;
  assign status_word_o         = st_reg.status_word;
  assign instruction_pointer_o = st_reg.instruction_pointer;
  assign vector_base_o         = st_reg.vector_base_reg;
  assign privilege_mode_bit_o  = priv;
  assign bank_select_bit_o     = bank_sel;
  assign illegal_access_o      = st_reg.illegal;

endmodule

// >>> sim/regfile_props.sv
// Port-level checker of the banked register file: reset, mode bits, refusals and flow.
// Assumes one clock domain with the synchronous active-low reset of the core.
module regfile_props
  import regfile_pkg::*;
(
  input wire logic              mclk_i,
  input wire logic              rst_n_i,
  input wire gpr_req_s          gpr_req_i,
  input wire ctl_req_s          ctl_req_i,
  input wire sys_req_s          sys_req_i,
  input wire flow_req_s         flow_req_i,
  input wire logic [DATA_W-1:0] rd_a_o,
  input wire logic [DATA_W-1:0] rd_b_o,
  input wire logic [DATA_W-1:0] index_reg_o,
  input wire logic [DATA_W-1:0] ctl_rd_o,
  input wire logic [DATA_W-1:0] sys_rd_o,
  input wire logic [DATA_W-1:0] status_word_o,
  input wire logic [DATA_W-1:0] instruction_pointer_o,
  input wire logic [DATA_W-1:0] vector_base_o,
  input wire logic              privilege_mode_bit_o,
  input wire logic              bank_select_bit_o,
  input wire logic              illegal_access_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  wire logic enter_w = flow_req_i.exc_take | flow_req_i.irq_take;
  wire logic user_w = !privilege_mode_bit_o;
  wire logic ip_load_w = sys_req_i.load && sys_req_i.sel == SYS_IP;

  reset_values_a: assert property ($rose(rst_n_i) |-> status_word_o == SW_RESET &&
    instruction_pointer_o == IP_RESET && vector_base_o == VBR_RESET) else $error("reset values wrong");
  exc_enter_a: assert property (enter_w |=> privilege_mode_bit_o && bank_select_bit_o)
    else $error("exception did not enter privileged bank one");
  exc_vector_a: assert property (enter_w |=> instruction_pointer_o ==
    $past(vector_base_o) + $past(flow_req_i.vec_offset)) else $error("exception pointer wrong");
  mode_bits_a: assert property (privilege_mode_bit_o == status_word_o[SW_MODE_POS] &&
    bank_select_bit_o == status_word_o[SW_BANK_POS] && (status_word_o & ~SW_VALID_MASK) == '0)
    else $error("mode bits differ from status");
  user_ctl_deny_a: assert property (user_w && ctl_req_i.load && !enter_w &&
    ctl_req_i.sel inside {CTL_SSTAT, CTL_SRET, CTL_VBASE} |=> illegal_access_o && $stable(vector_base_o))
    else $error("user control load not refused");
  user_sw_deny_a: assert property (user_w && ctl_req_i.load && ctl_req_i.sel == CTL_STATUS &&
    ((ctl_req_i.data ^ status_word_o) & SW_PRIV_MASK) != '0 && !enter_w && !flow_req_i.ret_exc
    |=> illegal_access_o && $stable(status_word_o)) else $error("user status load not refused");
  user_ret_deny_a: assert property (user_w && flow_req_i.ret_exc && !enter_w &&
    !flow_req_i.ip_step && !ip_load_w |=> illegal_access_o && $stable(instruction_pointer_o))
    else $error("user return not refused");
  illegal_cause_a: assert property (illegal_access_o |-> !$past(privilege_mode_bit_o))
    else $error("illegal pulse outside user mode");
  ip_step_a: assert property (flow_req_i.ip_step && !enter_w && !flow_req_i.ret_exc && !ip_load_w
    |=> instruction_pointer_o == $past(instruction_pointer_o) + IP_STEP) else $error("pointer step wrong");
  ip_store_a: assert property (sys_req_i.store && sys_req_i.sel == SYS_IP
    |=> sys_rd_o == $past(instruction_pointer_o)) else $error("pointer store wrong");
  cover property (enter_w);
  cover property (illegal_access_o);
  cover property (privilege_mode_bit_o && flow_req_i.ret_exc);
endmodule

bind banked_cpu_register_file regfile_props props_u (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .gpr_req_i(gpr_req_i), .ctl_req_i(ctl_req_i),
  .sys_req_i(sys_req_i), .flow_req_i(flow_req_i), .rd_a_o(rd_a_o), .rd_b_o(rd_b_o),
  .index_reg_o(index_reg_o), .ctl_rd_o(ctl_rd_o), .sys_rd_o(sys_rd_o), .status_word_o(status_word_o),
  .instruction_pointer_o(instruction_pointer_o), .vector_base_o(vector_base_o),
  .privilege_mode_bit_o(privilege_mode_bit_o), .bank_select_bit_o(bank_select_bit_o),
  .illegal_access_o(illegal_access_o)
);

// >>> sim/pipe_model.sv
// Model of the decode and execute pipeline that feeds the register file.
// Assumes the bench calls issue, which holds one set of requests for one clock.
module pipe_model
  import regfile_pkg::*;
(
  input  wire logic mclk_i,
  output gpr_req_s  gpr_req_o,
  output ctl_req_s  ctl_req_o,
  output sys_req_s  sys_req_o,
  output flow_req_s flow_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    gpr_req_o = '0;
    ctl_req_o = '0;
    sys_req_o = '0;
    flow_req_o = '0;
  end
  // Read numbers stay as levels; every strobe lasts exactly one clock.
  task automatic issue(input gpr_req_s g, input ctl_req_s c, input sys_req_s s, input flow_req_s f);
    @(negedge mclk_i);
    gpr_req_o <= g;
    ctl_req_o <= c;
    sys_req_o <= s;
    flow_req_o <= f;
    @(negedge mclk_i);
    gpr_req_o.wr_en <= 1'b0;
    ctl_req_o <= '0;
    sys_req_o <= '0;
    flow_req_o <= '0;
  endtask
endmodule

// >>> sim/tb_top.sv
// Self-checking bench of the banked register file with a pipeline model in front.
// Assumes the model drives requests on the falling edge and results settle one clock later.
module tb_top
  import regfile_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              mclk_i;
  logic              rst_n_i;
  gpr_req_s          gpr_req_i;
  ctl_req_s          ctl_req_i;
  sys_req_s          sys_req_i;
  flow_req_s         flow_req_i;
  logic [DATA_W-1:0] rd_a_o, rd_b_o, index_reg_o, ctl_rd_o, sys_rd_o, sw_o, ip_o, vb_o;
  logic              md_o, rb_o, ill_o;
  logic [DATA_W-1:0] b0 [8] = '{default: '0};
  logic [DATA_W-1:0] b1 [8] = '{default: '0};
  logic [DATA_W-1:0] un [8] = '{default: '0};
  logic [31:0]       seed = 32'hc8df_21d1;
  int                err_count = 0;
  int                check_count = 0;
  ctl_sel_e          psel [4] = '{CTL_SSTAT, CTL_SRET, CTL_VBASE, CTL_BANK};
  sys_sel_e          ssel [3] = '{SYS_MUL_ACC_HIGH, SYS_MUL_ACC_LOW, SYS_PROC};

  pipe_model pm_u (.mclk_i(mclk_i), .gpr_req_o(gpr_req_i), .ctl_req_o(ctl_req_i), .sys_req_o(sys_req_i),
    .flow_req_o(flow_req_i));
  banked_cpu_register_file dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .gpr_req_i(gpr_req_i),
    .ctl_req_i(ctl_req_i), .sys_req_i(sys_req_i), .flow_req_i(flow_req_i), .rd_a_o(rd_a_o), .rd_b_o(rd_b_o),
    .index_reg_o(index_reg_o), .ctl_rd_o(ctl_rd_o), .sys_rd_o(sys_rd_o), .status_word_o(sw_o),
    .instruction_pointer_o(ip_o), .vector_base_o(vb_o), .privilege_mode_bit_o(md_o),
    .bank_select_bit_o(rb_o), .illegal_access_o(ill_o));

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] exp_gpr(input int j, input logic md, input logic rb);
    if (j > 7) return un[j-8];
    return (md && rb) ? b1[j] : b0[j];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkf(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // Kind k: 0 write, 1 read, 2/3 control load/store, 4/5 system load/store, 6 exc, 7 irq, 8 return, 9 step.
  task automatic op(input int k, input logic [31:0] i, input logic [31:0] d);
    gpr_req_s g;
    ctl_req_s c;
    sys_req_s s;
    flow_req_s f;
    g = '{idx_a: i[3:0], idx_b: i[3:0], wr_en: k == 0, wr_idx: i[3:0], wr_data: d};
    c = '{load: k == 2, store: k == 3, sel: ctl_sel_e'(i[6:4]), bank_idx: i[2:0], data: d};
    s = '{load: k == 4, store: k == 5, sel: sys_sel_e'(i[5:4]), data: d};
    f = '{exc_take: k == 6, irq_take: k == 7, ret_exc: k == 8, ip_step: k == 9, vec_offset: d};
    pm_u.issue(g, c, s, f);
  endtask

  task automatic wr(input int j, input logic [31:0] d, input logic md, input logic rb);
    op(0, j, d);
    if (j > 7) un[j-8] = d;
    else if (md && rb) b1[j] = d;
    else b0[j] = d;
  endtask

  task automatic rd_all(input logic md, input logic rb);
    for (int j = 0; j < 16; j++) begin
      op(1, j, '0);
      chk(rd_a_o, exp_gpr(j, md, rb));
      chk(rd_b_o, exp_gpr(j, md, rb));
      if (md && j < 8) begin
        op(3, {CTL_BANK, 4'(j)}, '0);
        chk(ctl_rd_o, rb ? b0[j] : b1[j]);
      end
    end
  endtask

  task automatic sys_rt(input logic [31:0] ip_exp);
    logic [31:0] d;
    for (int n = 0; n < 3; n++) begin
      d = rnd();
      op(4, {ssel[n], 4'h0}, d);
      op(5, {ssel[n], 4'h0}, '0);
      chk(sys_rd_o, d);
    end
    op(5, {SYS_IP, 4'h0}, '0);
    chk(sys_rd_o, ip_exp);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    finish_test();
  end

  initial begin
    logic [31:0] d, off, v;
    rst_n_i = 1'b0;
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i) rst_n_i = 1'b1;
    chk(sw_o, SW_RESET);
    chk(ip_o, IP_RESET);
    chk(vb_o, VBR_RESET);
    for (int j = 0; j < 8; j++) begin
      b0[j] = rnd();
      op(2, {CTL_BANK, 4'(j)}, b0[j]);
    end
    for (int j = 0; j < 16; j++) wr(j, rnd(), 1'b1, 1'b1);
    rd_all(1'b1, 1'b1);
    op(2, {CTL_STATUS, 4'h0}, SW_RESET & ~(32'h1 << SW_BANK_POS));
    chkf(rb_o, 1'b0);
    rd_all(1'b1, 1'b0);
    op(2, {CTL_STATUS, 4'h0}, 32'h0000_0000);
    chkf(md_o, 1'b0);
    for (int j = 0; j < 8; j++) wr(j, rnd(), 1'b0, 1'b0);
    rd_all(1'b0, 1'b0);
    chk(index_reg_o, b0[0]);
    op(2, {CTL_STATUS, 4'h0}, 32'h2000_0000);
    chkf(ill_o, 1'b1);
    chk(sw_o, 32'h0000_0000);
    op(2, {CTL_STATUS, 4'h0}, 32'h0000_0001);
    chkf(ill_o, 1'b0);
    chk(sw_o, 32'h0000_0001);
    op(3, {CTL_STATUS, 4'h0}, '0);
    chk(ctl_rd_o, 32'h0000_0001);
    chkf(ill_o, 1'b0);
    for (int n = 0; n < 4; n++) begin
      op(2, {psel[n], 4'h0}, rnd());
      chkf(ill_o, 1'b1);
      op(3, {psel[n], 4'h0}, '0);
      chkf(ill_o, 1'b1);
    end
    chk(vb_o, VBR_RESET);
    d = rnd();
    op(2, {CTL_GBASE, 4'h0}, d);
    op(3, {CTL_GBASE, 4'h0}, '0);
    chk(ctl_rd_o, d);
    sys_rt(IP_RESET);
    op(8, '0, '0);
    chkf(ill_o, 1'b1);
    off = rnd() & 32'h0000_FFFC;
    op(6, '0, off);
    chk(ip_o, VBR_RESET + off);
    chkf(md_o, 1'b1);
    chkf(rb_o, 1'b1);
    rd_all(1'b1, 1'b1);
    sys_rt(VBR_RESET + off);
    op(3, {CTL_SRET, 4'h0}, '0);
    chk(ctl_rd_o, IP_RESET);
    op(3, {CTL_SSTAT, 4'h0}, '0);
    chk(ctl_rd_o, 32'h0000_0001);
    op(8, '0, '0);
    chk(ip_o, IP_RESET);
    chkf(md_o, 1'b0);
    op(9, '0, '0);
    chk(ip_o, IP_RESET + IP_STEP);
    op(7, '0, off);
    chkf(md_o, 1'b1);
    v = rnd() & 32'hFFFF_F000;
    op(2, {CTL_VBASE, 4'h0}, v);
    chk(vb_o, v);
    op(6, '0, off);
    chk(ip_o, v + off);
    for (int n = 0; n < 40; n++) begin
      d = rnd();
      wr(d[3:0], rnd(), 1'b1, 1'b1);
      op(1, d[7:4], '0);
      chk(rd_a_o, exp_gpr(d[7:4], 1'b1, 1'b1));
    end
    @(negedge mclk_i) rst_n_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    rst_n_i = 1'b1;
    chk(sw_o, SW_RESET);
    finish_test();
  end
endmodule
